/* File: logic/asc_ctrl.v */
/*
 Host-side controller for an asynchronous 512K x 8 static memory.
 Assumes the memory's data pins are joined to DQ_O/DQ_OE_O/DQ_I by the
 surrounding wiring, and that all inputs except RESET_N_I are synchronous to CLK_I.
*/
// Summary of operation
// - Write when chip select and strobe low
// - Read with select, gate low, strobe high
// - First rising select or strobe ends write
// - Data timed to terminating rising edge
// - Address stable 60 ns before write end
// - Data valid 30 ns before write end
// - Strobe write with gate low lengthens cycle
// - Never drive bus while device drives it
// - Wait one read cycle after retention
`timescale 1ns/1ns
`default_nettype none
`include "asc_defs.vh"

module asc_ctrl #(
	parameter ADDR_W = `ASC_ADDR_W,
	parameter DATA_W = `ASC_DATA_W
) (
	input wire CLK_I,
	input wire RESET_N_I,
	input wire REQ_I,
	input wire WRITE_I,
	input wire [ADDR_W-1:0] ADDR_I,
	input wire [DATA_W-1:0] WDATA_I,
	input wire RETENTION_EXIT_I,
	input wire [DATA_W-1:0] DQ_I,
	output reg READY_O,
	output reg DONE_O,
	output reg [DATA_W-1:0] RDATA_O,
	output reg [ADDR_W-1:0] MEM_ADDR_O,
	output reg MEM_CS_N_O,
	output reg MEM_WE_N_O,
	output reg MEM_OE_N_O,
	output reg [DATA_W-1:0] DQ_O,
	output reg DQ_OE_O
);

	localparam integer RD_CYC_I = `ASC_CYC(`ASC_ADDR_ACCESS_NS);
	localparam integer WR_CYC_I = `ASC_CYC(`ASC_ADDR_SETUP_NS);
	localparam integer REC_CYC_I = `ASC_CYC(`ASC_READ_CYCLE_NS);
	localparam integer TA_CYC_I = `ASC_CYC(`ASC_OE_HIGHZ_NS);
	localparam [`ASC_CNT_W-1:0] RD_CYC = RD_CYC_I[`ASC_CNT_W-1:0];
	localparam [`ASC_CNT_W-1:0] WR_CYC = WR_CYC_I[`ASC_CNT_W-1:0];
	localparam [`ASC_CNT_W-1:0] REC_CYC = REC_CYC_I[`ASC_CNT_W-1:0];
	localparam [`ASC_CNT_W-1:0] TA_CYC = TA_CYC_I[`ASC_CNT_W-1:0];

	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_READ = 3'h1;
	localparam [2:0] S_WRITE = 3'h2;
	localparam [2:0] S_WEND = 3'h3;
	localparam [2:0] S_TURN = 3'h4;
	localparam [2:0] S_RECOV = 3'h5;

	reg rst_meta_reg;
	reg rst_sync_reg;
	wire rst_n = rst_sync_reg;

	always @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [`ASC_CNT_W-1:0] cnt_reg;
	reg [`ASC_CNT_W-1:0] cnt_next;
	wire cnt_done = (cnt_reg == `ASC_CNT_ONE);

	always @* begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		if (cnt_reg != `ASC_CNT_ZERO)
			cnt_next = cnt_reg - `ASC_CNT_ONE;
		case (state_reg)
			S_IDLE: begin
				if (RETENTION_EXIT_I) begin
					state_next = S_RECOV;
					cnt_next = REC_CYC;
				end else if (REQ_I && WRITE_I) begin
					state_next = S_WRITE;
					cnt_next = WR_CYC;
				end else if (REQ_I) begin
					state_next = S_READ;
					cnt_next = RD_CYC;
				end
			end
			S_READ: begin
				if (cnt_done) begin
					state_next = S_TURN;
					cnt_next = TA_CYC;
				end
			end
			S_WRITE: begin
				if (cnt_done)
					state_next = S_WEND;
			end
			S_WEND: begin
				state_next = S_IDLE;
			end
			S_TURN: begin
				if (cnt_done)
					state_next = S_IDLE;
			end
			S_RECOV: begin
				if (cnt_done)
					state_next = S_IDLE;
			end
			default: begin
				state_next = S_IDLE;
			end
		endcase
	end

	// Pure decode of the state pair, shared by several output groups
	function launch;
		input [2:0] cur;
		input [2:0] nxt;
		input [2:0] target;
		begin
			launch = (cur == S_IDLE) && (nxt == target);
		end
	endfunction

	wire rd_launch = launch(state_reg, state_next, S_READ);
	wire wr_launch = launch(state_reg, state_next, S_WRITE);
	wire rd_end = (state_reg == S_READ) && (state_next == S_TURN);
	wire wr_end = (state_reg == S_WEND);

	always @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= S_IDLE;
			cnt_reg <= `ASC_CNT_ZERO;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
		end
	end

	// Retention exit wins over a request seen in the same cycle
	always @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			READY_O <= 1'b0;
			DONE_O <= 1'b0;
		end else begin
			READY_O <= (state_next == S_IDLE) && !RETENTION_EXIT_I;
			DONE_O <= rd_end || wr_end;
		end
	end

	// Sampled a full cycle after the strobes fell, past the access time
	always @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			RDATA_O <= {DATA_W{1'b0}};
		end else if (rd_end) begin
			RDATA_O <= DQ_I;
		end
	end

	// Held through the trailing select cycle so address hold is met
	always @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			MEM_ADDR_O <= {ADDR_W{1'b0}};
			DQ_O <= {DATA_W{1'b0}};
		end else begin
			if (rd_launch || wr_launch) begin
				MEM_ADDR_O <= ADDR_I;
			end
			if (wr_launch) begin
				DQ_O <= WDATA_I;
			end
		end
	end

	always @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			MEM_CS_N_O <= 1'b1;
			MEM_WE_N_O <= 1'b1;
			MEM_OE_N_O <= 1'b1;
			DQ_OE_O <= 1'b0;
		end else if (rd_launch) begin
			MEM_CS_N_O <= 1'b0;
			MEM_OE_N_O <= 1'b0;
			MEM_WE_N_O <= 1'b1;
			DQ_OE_O <= 1'b0;
		end else if (wr_launch) begin
			// Strobes and data move together; setup counts from here
			DQ_OE_O <= 1'b1;
			MEM_OE_N_O <= 1'b1;
			MEM_CS_N_O <= 1'b0;
			MEM_WE_N_O <= 1'b0;
		end else if (state_next == S_WEND) begin
			// Strobe rises first; select and data held one more cycle
			MEM_WE_N_O <= 1'b1;
		end else if (rd_end) begin
			MEM_OE_N_O <= 1'b1;
			MEM_CS_N_O <= 1'b1;
		end else if (wr_end) begin
			MEM_CS_N_O <= 1'b1;
			DQ_OE_O <= 1'b0;
		end
	end

endmodule // asc_ctrl
`default_nettype wire

/* File: logic/asc_defs.vh */
/*
 Timing and pin constants for the asynchronous static memory controller.
 Assumes a 10 MHz system clock; included by the controller module.
*/
`ifndef ASC_DEFS_VH
`define ASC_DEFS_VH

`define ASC_CLK_PERIOD_NS 100
`define ASC_ADDR_W 19
`define ASC_DATA_W 8
// Access and write timing in ns
`define ASC_READ_CYCLE_NS 70
`define ASC_ADDR_ACCESS_NS 70
`define ASC_OE_ACCESS_NS 35
`define ASC_ADDR_SETUP_NS 60
`define ASC_DATA_SETUP_NS 30
`define ASC_WE_HIGHZ_NS 25
`define ASC_OE_HIGHZ_NS 25
// Least times round up to whole cycles, never below one
`define ASC_CYC(ns) ((((ns) + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS) < 1 ? 1 : \
	(((ns) + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS))
`define ASC_CNT_W 4
`define ASC_CNT_ZERO 4'h0
`define ASC_CNT_ONE 4'h1

`endif

/* File: tb/asc_sva.sv */
/* Pin-level checks on the controller; bound into asc_ctrl. */
`timescale 1ns/1ns
`default_nettype none
module asc_sva (
	input wire CLK_I,
	input wire RESET_N_I,
	input wire READY_O,
	input wire DONE_O,
	input wire RETENTION_EXIT_I,
	input wire [7:0] RDATA_O,
	input wire [7:0] DQ_I,
	input wire [7:0] DQ_O,
	input wire [18:0] MEM_ADDR_O,
	input wire MEM_CS_N_O,
	input wire MEM_WE_N_O,
	input wire MEM_OE_N_O,
	input wire DQ_OE_O
);
default clocking @(posedge CLK_I); endclocking
default disable iff (!RESET_N_I);
AST_NOCONT: assert property (DQ_OE_O |-> MEM_OE_N_O) else $error("bus clash");
AST_WEOE: assert property (!MEM_WE_N_O |-> MEM_OE_N_O) else $error("gate in write");
AST_WBEG: assert property ($fell(MEM_WE_N_O) |-> !MEM_CS_N_O && DQ_OE_O) else $error("wr start");
AST_WEND: assert property ($rose(MEM_WE_N_O) |-> $past(!MEM_CS_N_O) && $past(DQ_OE_O) &&
	$stable(MEM_ADDR_O) && $stable(DQ_O)) else $error("wr setup");
AST_WTERM: assert property ($rose(MEM_WE_N_O) |-> !MEM_CS_N_O ##1
	(MEM_CS_N_O && DONE_O && !DQ_OE_O)) else $error("wr end");
AST_RD: assert property ($fell(MEM_OE_N_O) |-> MEM_WE_N_O && !MEM_CS_N_O && !DQ_OE_O ##1
	(MEM_OE_N_O && DONE_O)) else $error("rd cycle");
AST_RDATA: assert property (DONE_O && $past(MEM_OE_N_O) == 0 |-> RDATA_O == $past(DQ_I))
	else $error("rd data");
AST_RECOV: assert property (RETENTION_EXIT_I && READY_O |=> !READY_O && MEM_CS_N_O ##1 READY_O)
	else $error("recovery");
endmodule // asc_sva
bind asc_ctrl asc_sva u_sva (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .READY_O(READY_O),
	.DONE_O(DONE_O), .RETENTION_EXIT_I(RETENTION_EXIT_I), .RDATA_O(RDATA_O), .DQ_I(DQ_I),
	.DQ_O(DQ_O), .MEM_ADDR_O(MEM_ADDR_O), .MEM_CS_N_O(MEM_CS_N_O), .MEM_WE_N_O(MEM_WE_N_O),
	.MEM_OE_N_O(MEM_OE_N_O), .DQ_OE_O(DQ_OE_O));
`default_nettype wire

/* File: tb/asc_mem_model.sv */
/* Behavioural 512K x 8 memory; bus_o is the resolved data wire. */
`timescale 1ns/1ns
`default_nettype none
module asc_mem_model #(parameter ACC_NS = 70) (
	input wire [18:0] a_i,
	input wire cs_n_i,
	input wire we_n_i,
	input wire oe_n_i,
	input wire host_oe_i,
	input wire [7:0] host_d_i,
	output wire [7:0] bus_o
);
reg [7:0] mem [0:19'h7FFFF];
reg [7:0] last = 8'h00;
wire drv = !cs_n_i && !oe_n_i && we_n_i;
wire [7:0] q;
assign #ACC_NS q = mem[a_i];
// Floating wire shows inverse of last value, not a convenient copy
assign bus_o = host_oe_i ? host_d_i : drv ? q : ~last;
always @* if (host_oe_i) last = host_d_i; else if (drv) last = q;
always @* if (!cs_n_i && !we_n_i) mem[a_i] = bus_o;
endmodule // asc_mem_model
`default_nettype wire

/* File: tb/test_async_sram_512k_x8.sv */
/* Random and corner accesses through the controller to the memory model. */
`timescale 1ns/1ns
`default_nettype none
module test_async_sram_512k_x8;
reg CLK_I = 0, RESET_N_I = 0, REQ_I = 0, WRITE_I = 0, RETENTION_EXIT_I = 0;
reg [18:0] ADDR_I = 0, addr;
reg [7:0] WDATA_I = 0;
reg [7:0] ref_m [0:19'h7FFFF];
reg [16:0] seed = 17'h11A85;
wire READY_O, DONE_O, MEM_CS_N_O, MEM_WE_N_O, MEM_OE_N_O, DQ_OE_O;
wire [7:0] RDATA_O, DQ_O, DQ_I;
wire [18:0] MEM_ADDR_O;
integer failures = 0, num_checks = 0, cyc = 0, i, n;
asc_ctrl DUT (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .REQ_I(REQ_I), .WRITE_I(WRITE_I),
	.ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .RETENTION_EXIT_I(RETENTION_EXIT_I), .DQ_I(DQ_I),
	.READY_O(READY_O), .DONE_O(DONE_O), .RDATA_O(RDATA_O), .MEM_ADDR_O(MEM_ADDR_O),
	.MEM_CS_N_O(MEM_CS_N_O), .MEM_WE_N_O(MEM_WE_N_O), .MEM_OE_N_O(MEM_OE_N_O),
	.DQ_O(DQ_O), .DQ_OE_O(DQ_OE_O));
asc_mem_model mem (.a_i(MEM_ADDR_O), .cs_n_i(MEM_CS_N_O), .we_n_i(MEM_WE_N_O),
	.oe_n_i(MEM_OE_N_O), .host_oe_i(DQ_OE_O), .host_d_i(DQ_O), .bus_o(DQ_I));
always #50 CLK_I = ~CLK_I;
always @(posedge CLK_I) begin
	cyc = cyc + 1;
	if (cyc == 3000) begin
		failures = failures + 1;
		tally_and_finish;
	end
end
function [16:0] lfsr(input [16:0] s);
	lfsr = {s[15:0], s[16] ^ s[13]};
endfunction
task check(input [63:0] nm, input [18:0] seen, input [18:0] exp);
	begin
		num_checks = num_checks + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("[ERR] %0s exp %h seen %h", nm, exp, seen);
		end
	end
endtask
task acc(input w, input [18:0] a, input [7:0] d);
	begin
		n = 0;
		while (READY_O !== 1'b1 && n < 20) @(negedge CLK_I) n = n + 1;
		REQ_I = 1;
		WRITE_I = w;
		ADDR_I = a;
		WDATA_I = d;
		@(negedge CLK_I) REQ_I = 0;
		n = 0;
		while (DONE_O !== 1'b1 && n < 9) @(negedge CLK_I) n = n + 1;
		check("latency", n, w ? 2 : 1);
		if (w) ref_m[a] = d;
		else check("rdata", RDATA_O, ref_m[a]);
	end
endtask
task tally_and_finish;
	begin
		if (failures == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	end
endtask
initial begin
	repeat (12) @(negedge CLK_I);
	RESET_N_I = 1;
	for (i = 0; i < 40; i = i + 1) begin
		seed = lfsr(seed);
		addr = i == 0 ? 19'h0 : i == 1 ? 19'h7FFFF : {seed, seed[1:0]};
		acc(1, addr, seed[7:0] ^ seed[16:9]);
		acc(0, addr, 8'h00);
	end
	acc(0, 19'h0, 8'h00);
	while (READY_O !== 1'b1) @(negedge CLK_I);
	RETENTION_EXIT_I = 1;
	REQ_I = 1;
	WRITE_I = 1;
	ADDR_I = 19'h0;
	WDATA_I = ~ref_m[0];
	@(negedge CLK_I) RETENTION_EXIT_I = 0;
	REQ_I = 0;
	check("ready", READY_O, 0);
	check("cs_n", MEM_CS_N_O, 1);
	@(negedge CLK_I) check("ready", READY_O, 1);
	acc(0, 19'h0, 8'h00);
	acc(0, 19'h7FFFF, 8'h00);
	tally_and_finish;
end
endmodule // test_async_sram_512k_x8
`default_nettype wire
